// file: rtl/power_mode_and_por_control.sv
// module: power modes, wake decisions and power-on-reset sequencing
//
// Behaviour
// - software selects idle or full power-down
// - idle keeps oscillator, gates core clock only
// - peripherals stay clocked during idle
// - idle holds port and converter output pins
// - idle ends on enabled interrupt or reset
// - power-down stops oscillator and all peripherals
// - power-down holds ports, converter output three-state
// - reset pin in power-down restarts normally
// - supply cycle resets, runs after timeout
// - interval counter interrupt ends power-down, serviced
// - after wake service, resume after entry instruction
// - serial interrupt wakes only with serial enable
// - external interrupt zero wakes only when enabled
// - hold reset below threshold, then timeout
// - timeout counted in oscillator cycles
// - on supply fall, hold reset until floor
// - converters and reference switchable off by software
`timescale 1ns/1ps
module power_mode_and_por_control
    import power_mode_pkg::*;
#(
    parameter int unsigned N_IRQ = IRQ_COUNT,
    parameter int unsigned POR_CYCLES = POR_OSC_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic osc_tick,
    input wire logic osc_ready,
    input wire supply_t supply,
    input wire logic reset_pin_n,
    input wire logic mode_req_valid,
    input wire logic [1:0] mode_req,
    input wire power_control_register_t power_control_register,
    input wire logic [N_IRQ-1:0] irq_pending,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic tic_irq,
    input wire logic tic_irq_enable,
    input wire logic serial_irq,
    input wire logic serial_irq_enable,
    input wire logic ext0_n,
    input wire logic ext0_irq_enable,
    output power_ctl_t ctl_q,
    output pm_state_t mode_q,
    output logic wake_service_q,
    output logic resume_next_q,
    output wake_src_t wake_src_q
);

    localparam int unsigned CNT_W = (POR_CYCLES > 1) ? $clog2(POR_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    pm_state_t state_d;
    power_ctl_t ctl_d;
    wake_src_t pd_wake;
    logic idle_wake;
    logic por_done;
    logic [CNT_W-1:0] por_cnt_q;

    // switch settings that belong to each state
    function automatic power_ctl_t ctl_for(input pm_state_t s,
                                           input power_control_register_t p);
        power_ctl_t c;
        logic analog_on;
        c = '0;
        analog_on = (s == ST_RUN) || (s == ST_IDLE);
        c.core_clk_en = (s == ST_RUN);
        c.periph_clk_en = (s == ST_RUN) || (s == ST_IDLE);
        c.osc_enable = (s != ST_PDOWN);
        c.sys_reset_n = (s == ST_RUN) || (s == ST_IDLE) ||
                        (s == ST_PDOWN) || (s == ST_OSC_START);
        c.port_hold = (s == ST_IDLE) || (s == ST_PDOWN) ||
                      (s == ST_OSC_START);
        c.dac_hold = (s == ST_IDLE);
        c.dac_hiz = (s == ST_PDOWN) || (s == ST_OSC_START);
        c.adc_power = analog_on && p.adc_enable;
        c.dac_power = analog_on && p.dac_enable;
        c.vref_power = analog_on && p.vref_enable;
        return c;
    endfunction : ctl_for

    // wake decisions are pure gates, so no oscillator edge is needed
    always_comb begin
        idle_wake = |(irq_pending & irq_enable);
        pd_wake.interval_counter = tic_irq && tic_irq_enable;
        pd_wake.serial = serial_irq && serial_irq_enable &&
                         power_control_register.serial_wake_enable;
        pd_wake.external_interrupt_zero = !ext0_n && ext0_irq_enable &&
                                          power_control_register.ext0_wake_enable;
    end

    assign por_done = osc_tick && (por_cnt_q == CNT_LAST);

    always_comb begin
        state_d = mode_q;
        unique case (mode_q)
            ST_POR_HOLD: begin
                if (supply.above_por) begin
                    state_d = ST_POR_WAIT;
                end
            end
            ST_POR_WAIT: begin
                if (!supply.above_por) begin
                    state_d = ST_POR_HOLD;
                end else if (por_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_POR_FALL: begin
                if (!supply.above_floor) begin
                    state_d = ST_POR_HOLD;
                end else if (supply.above_por) begin
                    state_d = ST_POR_WAIT;
                end
            end
            ST_EXT_RST: begin
                if (reset_pin_n && osc_ready) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (mode_req_valid && mode_req == MODE_REQ_IDLE) begin
                    state_d = ST_IDLE;
                end else if (mode_req_valid && mode_req == MODE_REQ_PDOWN) begin
                    state_d = ST_PDOWN;
                end
            end
            ST_IDLE: begin
                if (idle_wake) begin
                    state_d = ST_RUN;
                end
            end
            ST_PDOWN: begin
                // other events, except the reset pin and a supply fall, keep the chip asleep
                if (|pd_wake) begin
                    state_d = ST_OSC_START;
                end
            end
            ST_OSC_START: begin
                if (osc_ready) begin
                    state_d = ST_RUN;
                end
            end
        endcase
        // supply and reset pin override every non-reset state
        if (mode_q != ST_POR_HOLD && mode_q != ST_POR_WAIT &&
            mode_q != ST_POR_FALL) begin
            if (!supply.above_por) begin
                state_d = ST_POR_FALL;
            end else if (!reset_pin_n) begin
                state_d = ST_EXT_RST;
            end
        end
    end

    assign ctl_d = ctl_for(state_d, power_control_register);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= ST_POR_HOLD;
        end else if (clk_en) begin
            mode_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_q <= '0;
        end else if (clk_en) begin
            ctl_q <= ctl_d;
        end
    end

    // timeout counts oscillator ticks, so it scales with the crystal
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt_q <= CNT_ZERO;
        end else if (clk_en) begin
            if (mode_q != ST_POR_WAIT || !supply.above_por) begin
                por_cnt_q <= CNT_ZERO;
            end else if (osc_tick && por_cnt_q != CNT_LAST) begin
                por_cnt_q <= por_cnt_q + 1'b1;
            end
        end
    end

    // service request to the core once it runs again
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_service_q <= 1'b0;
            resume_next_q <= 1'b0;
        end else if (clk_en) begin
            wake_service_q <= state_d == ST_RUN &&
                              (mode_q == ST_IDLE ||
                               mode_q == ST_OSC_START);
            resume_next_q <= state_d == ST_RUN &&
                             mode_q == ST_OSC_START;
        end
    end

    // which power-down event woke the chip, kept until the next entry, reset pin or supply fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_src_q <= WAKE_SRC_RESET;
        end else if (clk_en) begin
            if (mode_q == ST_PDOWN && state_d == ST_OSC_START) begin
                wake_src_q <= pd_wake;
            end else if (state_d == ST_PDOWN || state_d == ST_EXT_RST ||
                         state_d == ST_POR_FALL) begin
                wake_src_q <= WAKE_SRC_RESET;
            end
        end
    end

    // ---- assertions ----
    a_idle_core_gated: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_IDLE |-> !ctl_q.core_clk_en && ctl_q.periph_clk_en &&
        ctl_q.osc_enable)
        else $error("idle mode clocks wrong");

    a_pdown_osc_off: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_PDOWN |-> !ctl_q.osc_enable && !ctl_q.periph_clk_en &&
        !ctl_q.adc_power && !ctl_q.dac_power && !ctl_q.vref_power)
        else $error("power-down left something running");

    a_pdown_pins: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_PDOWN |-> ctl_q.port_hold && ctl_q.dac_hiz &&
        !ctl_q.dac_hold)
        else $error("power-down pin state wrong");

    a_idle_pins: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_IDLE |-> ctl_q.port_hold && ctl_q.dac_hold &&
        !ctl_q.dac_hiz)
        else $error("idle pin state wrong");

    a_mode_entry: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_RUN && supply.above_por && reset_pin_n &&
        mode_req_valid && mode_req == MODE_REQ_PDOWN |=> mode_q == ST_PDOWN)
        else $error("power-down request not taken");

    a_idle_exit: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_IDLE && supply.above_por && reset_pin_n &&
        idle_wake |=> mode_q == ST_RUN && wake_service_q)
        else $error("enabled interrupt did not end idle");

    a_serial_gate: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_PDOWN && supply.above_por && reset_pin_n &&
        !pd_wake.interval_counter && !pd_wake.external_interrupt_zero &&
        !power_control_register.serial_wake_enable |=> mode_q == ST_PDOWN)
        else $error("serial event woke without its enable");

    a_ext0_wake: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_PDOWN && supply.above_por && reset_pin_n &&
        !ext0_n && ext0_irq_enable && power_control_register.ext0_wake_enable
        |=> mode_q == ST_OSC_START && ctl_q.osc_enable)
        else $error("external interrupt zero did not wake");

    a_resume_pair: assert property (@(posedge clk) disable iff (!reset_n)
        resume_next_q |-> wake_service_q && $past(mode_q) == ST_OSC_START)
        else $error("resume flag without power-down wake");

    a_reset_pin: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_PDOWN && supply.above_por && !reset_pin_n
        |=> mode_q == ST_EXT_RST && !ctl_q.sys_reset_n &&
        ctl_q.osc_enable)
        else $error("reset pin ignored in power-down");

    a_por_hold: assert property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_POR_HOLD || mode_q == ST_POR_FALL
        |-> !ctl_q.sys_reset_n)
        else $error("chip out of reset with low supply");

    a_floor_hold: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_POR_FALL && supply.above_floor &&
        !supply.above_por |=> mode_q == ST_POR_FALL)
        else $error("reset left before supply reached floor");

    a_por_count: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_POR_WAIT && supply.above_por && !osc_tick
        |=> mode_q == ST_POR_WAIT && $stable(por_cnt_q))
        else $error("timeout advanced without oscillator tick");

    a_por_release: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_POR_WAIT && supply.above_por && por_done
        |=> mode_q == ST_RUN && ctl_q.sys_reset_n && ctl_q.core_clk_en)
        else $error("timeout end did not release reset");

    a_clk_freeze: assert property (@(posedge clk) disable iff (!reset_n)
        !clk_en |=> $stable(mode_q) && $stable(ctl_q) &&
        $stable(por_cnt_q))
        else $error("state moved while clock enable low");

    a_idle_no_resume: assert property (@(posedge clk) disable iff (!reset_n)
        wake_service_q && $past(mode_q) == ST_IDLE |-> !resume_next_q)
        else $error("resume flag after idle wake");

    a_service_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && wake_service_q |=> !wake_service_q)
        else $error("service request longer than one cycle");

    a_src_cleared: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_RUN && supply.above_por && reset_pin_n &&
        mode_req_valid && mode_req == MODE_REQ_PDOWN
        |=> wake_src_q == WAKE_SRC_RESET)
        else $error("wake source not cleared on power-down entry");

    a_pin_release: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_EXT_RST && supply.above_por && reset_pin_n &&
        osc_ready |=> mode_q == ST_RUN && ctl_q.sys_reset_n &&
        !wake_service_q)
        else $error("reset pin release did not restart");

    a_idle_reset: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && mode_q == ST_IDLE && supply.above_por && !reset_pin_n
        |=> mode_q == ST_EXT_RST && !ctl_q.sys_reset_n)
        else $error("reset pin did not end idle");

    c_idle_round: cover property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_IDLE ##[1:20] mode_q == ST_RUN);

    c_tic_wake: cover property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_PDOWN && pd_wake.interval_counter ##[1:20]
        resume_next_q);

    c_ext_reset_pd: cover property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_PDOWN ##1 mode_q == ST_EXT_RST);

    c_brownout: cover property (@(posedge clk) disable iff (!reset_n)
        mode_q == ST_POR_FALL ##[1:20] mode_q == ST_POR_HOLD);

endmodule : power_mode_and_por_control

// file: rtl/power_mode_pkg.sv
// package: constants and types of the power-mode and power-on-reset block
package power_mode_pkg;

    // power-on-reset timeout, as a time and as oscillator cycles
    localparam int unsigned POR_TIMEOUT_MS = 128;
    localparam int unsigned XTAL_REF_HZ = 16_000_000;
    localparam int unsigned POR_OSC_CYCLES =
        POR_TIMEOUT_MS * (XTAL_REF_HZ / 1000);

    // number of interrupt sources that may end idle mode
    localparam int unsigned IRQ_COUNT = 12;

    // mode request codes from the power control register
    localparam logic [1:0] MODE_REQ_NONE = 2'h0;
    localparam logic [1:0] MODE_REQ_IDLE = 2'h1;
    localparam logic [1:0] MODE_REQ_PDOWN = 2'h2;

    // reset value of the wake source report
    localparam logic [2:0] WAKE_SRC_RESET = 3'h0;

    typedef enum logic [2:0] {
        ST_POR_HOLD = 3'h0,
        ST_POR_WAIT = 3'h1,
        ST_POR_FALL = 3'h2,
        ST_EXT_RST = 3'h3,
        ST_RUN = 3'h4,
        ST_IDLE = 3'h5,
        ST_PDOWN = 3'h6,
        ST_OSC_START = 3'h7
    } pm_state_t;

    // power control register fields as the core holds them
    typedef struct packed {
        logic serial_wake_enable;
        logic ext0_wake_enable;
        logic adc_enable;
        logic dac_enable;
        logic vref_enable;
    } power_control_register_t;

    // events that may end full power-down
    typedef struct packed {
        logic interval_counter;
        logic serial;
        logic external_interrupt_zero;
    } wake_src_t;

    // supply level indications
    typedef struct packed {
        logic above_por;
        logic above_floor;
    } supply_t;

    // switches driven to the rest of the chip
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic osc_enable;
        logic sys_reset_n;
        logic port_hold;
        logic dac_hold;
        logic dac_hiz;
        logic adc_power;
        logic dac_power;
        logic vref_power;
    } power_ctl_t;

endpackage : power_mode_pkg

// file: testbench/power_mode_and_por_control_tb.sv
// testbench: power modes, wake events and power-on-reset sequencing
`timescale 1ns/1ps
module power_mode_and_por_control_tb
    import power_mode_pkg::*;
;
    localparam int unsigned POR_N = 8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic osc_tick = 1'b0;
    logic osc_ready = 1'b1;
    supply_t supply = '0;
    logic reset_pin_n = 1'b1;
    logic mode_req_valid = 1'b0;
    logic [1:0] mode_req = 2'h0;
    power_control_register_t power_control_register = '0;
    logic [11:0] irq_pending = '0;
    logic [11:0] irq_enable = '0;
    logic tic_irq = 1'b0;
    logic tic_irq_enable = 1'b0;
    logic serial_irq = 1'b0;
    logic serial_irq_enable = 1'b0;
    logic ext0_n = 1'b1;
    logic ext0_irq_enable = 1'b0;
    power_ctl_t ctl_q;
    pm_state_t mode_q;
    logic wake_service_q;
    logic resume_next_q;
    wake_src_t wake_src_q;
    int num_errors = 0;
    int checked = 0;

    power_mode_and_por_control #(.N_IRQ(12), .POR_CYCLES(POR_N)) uut (
        .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .osc_tick(osc_tick),
        .osc_ready(osc_ready), .supply(supply), .reset_pin_n(reset_pin_n),
        .mode_req_valid(mode_req_valid), .mode_req(mode_req), .power_control_register(power_control_register),
        .irq_pending(irq_pending), .irq_enable(irq_enable),
        .tic_irq(tic_irq), .tic_irq_enable(tic_irq_enable),
        .serial_irq(serial_irq), .serial_irq_enable(serial_irq_enable),
        .ext0_n(ext0_n), .ext0_irq_enable(ext0_irq_enable), .ctl_q(ctl_q),
        .mode_q(mode_q), .wake_service_q(wake_service_q),
        .resume_next_q(resume_next_q), .wake_src_q(wake_src_q)
    );

    always #2 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // expected wake source for power-down scenario s
    function automatic wake_src_t exp_src(input int s);
        exp_src = '{interval_counter: (s == 0), serial: (s == 1),
                    external_interrupt_zero: (s == 2)};
    endfunction : exp_src

    task automatic chk_bit(input logic got, input logic exp, input string w);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: %s is %b", $time, w, got);
        end
    endtask : chk_bit

    task automatic chk_mode(input pm_state_t exp);
        checked++;
        if (mode_q !== exp) begin
            num_errors++;
            $display("ERROR %0t: mode %h not %h", $time, mode_q, exp);
        end
    endtask : chk_mode

    task automatic chk_src(input wake_src_t exp);
        checked++;
        if (wake_src_q !== exp) begin
            num_errors++;
            $display("ERROR %0t: wake source %b", $time, wake_src_q);
        end
    endtask : chk_src

    // wait a bounded number of edges for a state, then compare
    task automatic wait_mode(input pm_state_t exp, input int max);
        for (int i = 0; i < max; i++) begin
            @(posedge clk);
            #1;
            if (mode_q === exp) break;
        end
        chk_mode(exp);
    endtask : wait_mode

    task automatic req(input logic [1:0] c);
        @(posedge clk);
        mode_req_valid <= 1'b1;
        mode_req <= c;
        @(posedge clk);
        mode_req_valid <= 1'b0;
        #1;
    endtask : req

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            osc_tick <= 1'b1;
            @(posedge clk);
            osc_tick <= 1'b0;
        end
    endtask : ticks

    task automatic por_up();
        @(posedge clk);
        supply <= '{above_por: 1'b1, above_floor: 1'b1};
        wait_mode(ST_POR_WAIT, 3);
        chk_bit(ctl_q.sys_reset_n, 1'b0, "reset during timeout");
        ticks(POR_N - 1);
        repeat (2) @(posedge clk);
        #1 chk_mode(ST_POR_WAIT);
        ticks(1);
        wait_mode(ST_RUN, 3);
        chk_bit(ctl_q.sys_reset_n, 1'b1, "released reset");
    endtask : por_up

    initial begin
        int b;
        wake_src_t e;
        void'($urandom(97639));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_mode(ST_POR_HOLD);
        chk_bit(ctl_q.sys_reset_n, 1'b0, "reset with low supply");
        por_up();
        for (int c = 0; c < 4; c += 3) begin
            req(2'(c));
            chk_mode(ST_RUN);
        end
        // idle: unmatched interrupts, then one enabled one
        req(MODE_REQ_IDLE);
        chk_mode(ST_IDLE);
        chk_bit(ctl_q.core_clk_en, 1'b0, "core clock in idle");
        chk_bit(ctl_q.osc_enable, 1'b1, "oscillator in idle");
        chk_bit(ctl_q.periph_clk_en, 1'b1, "periph clock idle");
        chk_bit(ctl_q.port_hold, 1'b1, "port hold idle");
        chk_bit(ctl_q.dac_hold, 1'b1, "dac hold idle");
        b = $urandom % 12;
        @(posedge clk);
        irq_enable <= 12'($urandom) & ~(12'h001 << b);
        irq_pending <= 12'h001 << b;
        repeat (4) @(posedge clk);
        #1 chk_mode(ST_IDLE);
        @(posedge clk);
        irq_enable[b] <= 1'b1;
        wait_mode(ST_RUN, 3);
        chk_bit(wake_service_q, 1'b1, "idle wake service");
        chk_bit(resume_next_q, 1'b0, "resume on idle wake");
        chk_bit(ctl_q.core_clk_en, 1'b1, "core clock back");
        @(posedge clk);
        irq_pending <= '0;
        // clock enable low: a request pulse must not be taken
        @(posedge clk);
        clk_en <= 1'b0;
        mode_req_valid <= 1'b1;
        mode_req <= MODE_REQ_IDLE;
        @(posedge clk);
        mode_req_valid <= 1'b0;
        @(posedge clk);
        #1 chk_mode(ST_RUN);
        chk_bit(ctl_q.core_clk_en, 1'b1, "core clock frozen");
        @(posedge clk);
        clk_en <= 1'b1;
        // power-down, each wake source refused then accepted
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            power_control_register <= power_control_register_t'({2'h0, 3'($urandom)});
            tic_irq_enable <= 1'b0;
            serial_irq_enable <= 1'b1;
            ext0_irq_enable <= 1'b1;
            repeat (3) @(posedge clk);
            #1 chk_bit(ctl_q.adc_power, power_control_register.adc_enable, "adc power");
            chk_bit(ctl_q.dac_power, power_control_register.dac_enable, "dac power");
            chk_bit(ctl_q.vref_power, power_control_register.vref_enable, "vref");
            req(MODE_REQ_PDOWN);
            osc_ready <= 1'b0;
            chk_mode(ST_PDOWN);
            chk_bit(ctl_q.osc_enable, 1'b0, "osc in power-down");
            chk_bit(ctl_q.periph_clk_en, 1'b0, "periph clk pd");
            chk_bit(ctl_q.adc_power, 1'b0, "adc power pd");
            chk_bit(ctl_q.port_hold, 1'b1, "port hold pd");
            chk_bit(ctl_q.dac_hiz, 1'b1, "dac three-state");
            @(posedge clk);
            tic_irq <= (s == 0);
            serial_irq <= (s == 1);
            ext0_n <= (s != 2);
            repeat (4) @(posedge clk);
            #1 chk_mode(ST_PDOWN);
            @(posedge clk);
            tic_irq_enable <= 1'b1;
            power_control_register.serial_wake_enable <= 1'b1;
            power_control_register.ext0_wake_enable <= 1'b1;
            wait_mode(ST_OSC_START, 3);
            e = exp_src(s);
            chk_src(e);
            chk_bit(ctl_q.osc_enable, 1'b1, "osc restart");
            chk_bit(ctl_q.core_clk_en, 1'b0, "core before osc");
            @(posedge clk);
            osc_ready <= 1'b1;
            wait_mode(ST_RUN, 3);
            chk_bit(wake_service_q, 1'b1, "pd wake service");
            chk_bit(resume_next_q, 1'b1, "resume after entry");
            @(posedge clk);
            tic_irq <= 1'b0;
            serial_irq <= 1'b0;
            ext0_n <= 1'b1;
        end
        // reset pin during power-down
        req(MODE_REQ_PDOWN);
        osc_ready <= 1'b0;
        reset_pin_n <= 1'b0;
        wait_mode(ST_EXT_RST, 3);
        chk_bit(ctl_q.sys_reset_n, 1'b0, "pin reset");
        @(posedge clk);
        reset_pin_n <= 1'b1;
        osc_ready <= 1'b1;
        wait_mode(ST_RUN, 3);
        chk_bit(ctl_q.sys_reset_n, 1'b1, "pin released");
        chk_bit(wake_service_q, 1'b0, "no service on pin");
        // supply falls, held until floor, then power returns
        @(posedge clk);
        supply.above_por <= 1'b0;
        wait_mode(ST_POR_FALL, 3);
        chk_bit(ctl_q.sys_reset_n, 1'b0, "reset on fall");
        repeat (4) @(posedge clk);
        #1 chk_mode(ST_POR_FALL);
        @(posedge clk);
        supply.above_floor <= 1'b0;
        wait_mode(ST_POR_HOLD, 3);
        por_up();
        report_and_stop();
    end

    initial begin
        #20000;
        num_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : power_mode_and_por_control_tb
